// ---- mac_engine_pkg.sv ----
// Constants, register map and packed carriers for the multiply-accumulate
// engine. Assumes a 32-bit APB register port with word-aligned registers.
package mac_engine_pkg;

    // Datapath widths
    localparam int OPERAND_W = 16;
    localparam int PRODUCT_W = 32;
    localparam int ACC_W     = 40;
    localparam int RND_W     = 16;
    localparam int BYTE_W    = 8;

    // Register byte addresses, one aligned word each
    localparam logic [7:0] ADDR_CONFIG   = 8'h00;
    localparam logic [7:0] ADDR_STATUS   = 8'h04;
    localparam logic [7:0] ADDR_OPER_A   = 8'h08;
    localparam logic [7:0] ADDR_OPER_B   = 8'h0C;
    localparam logic [7:0] ADDR_ACC_B0   = 8'h10;
    localparam logic [7:0] ADDR_ACC_B1   = 8'h14;
    localparam logic [7:0] ADDR_ACC_B2   = 8'h18;
    localparam logic [7:0] ADDR_ACC_B3   = 8'h1C;
    localparam logic [7:0] ADDR_ACC_OVR  = 8'h20;
    localparam logic [7:0] ADDR_RND_HIGH = 8'h24;
    localparam logic [7:0] ADDR_RND_LOW  = 8'h28;

    // Rounding and saturation figures
    localparam logic [15:0] ROUND_HALF = 16'h8000;
    localparam logic [15:0] SAT_POS    = 16'h7FFF;
    localparam logic [15:0] SAT_NEG    = 16'h8000;

    // Reset values
    localparam logic [5:0]  CONFIG_RESET = 6'h00;
    localparam logic [3:0]  STATUS_RESET = 4'h0;
    localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;

    // Configuration register, bits 5..0
    typedef struct packed {
        logic shift_command;
        logic shift_direction;
        logic clear_accumulator_cmd;
        logic saturate_enable;
        logic fractional_mode_select;
        logic multiply_only_select;
    } engine_config_t;

    // Status register, bits 3..0
    typedef struct packed {
        logic hardware_overflow_flag;
        logic zero_flag;
        logic soft_overflow_flag;
        logic negative_flag;
    } engine_status_t;

endpackage

// ---- multiply_accumulate_engine.sv ----
// Multiply-accumulate engine with 40-bit accumulator, shifter and rounding
// engine, reached as an APB slave. Assumes one clock domain (pclk) and a
// master that honours the APB setup/access sequence.
//
// Overview of operation
// RL1: Accumulate mode adds product to accumulator
// RL2: Three pipeline stages, one clock each
// RL3: Only operand B low byte write starts
// RL4: Stage one multiplies, stage two accumulates
// RL5: Status flags update after stage two
// RL6: Rounded, saturated result after stage three
// RL7: Clear bit zeroes accumulator, flags, itself
// RL8: Multiply-only mode adds product to zero
// RL9: Product in accumulator two clocks later
// RL10: Multiply-only leaves hardware overflow unchanged
// RL11: Shift command shifts, rounds, then self-clears
// RL12: Direction bit: zero left, one right
// RL13: Right shift replicates bit 39
// RL14: Shifts leave status flags unchanged
// RL15: Round at stage three, shift, byte0 write
// RL16: Rounding never alters the accumulator
// RL17: Rounding identical in integer, fractional mode
// RL18: Unbiased round-half-to-even on bits 31..16
// RL19: Saturate to 0x7FFF or 0x8000 when enabled
// RL20: Status reads 0x04 zero, 0x01 negative
// RL21: Integer mode: two's complement integer result
// RL22: Fractional mode: product shifted one left
// RL23: Accumulator as five byte registers
// RL24: Back-to-back starts accumulate correctly
// RL25: Zero/negative from full 40-bit result
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module multiply_accumulate_engine
    import mac_engine_pkg::*;
#(
    parameter int ADDR_W = 8        // APB address width
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr
);

    // Register map needs eight address bits
    // Refused at elaboration: a narrower bus
    // would alias registers onto each other.
    if (ADDR_W < 8) begin : g_addr_check
        $error("ADDR_W must be at least 8");
    end

    // Bus handshake state
    logic        pready_q;          // High in the completing access cycle
    logic [31:0] prdata_q;          // Read data captured before completion
    logic        pslverr_q;         // Unmapped address answer

    // Software-visible state
    engine_config_t          cfg_q;     // Configuration bits
    engine_status_t          sta_q;     // Status flags
    logic [OPERAND_W-1:0]    opa_q;     // Operand A
    logic [OPERAND_W-1:0]    opb_q;     // Operand B
    logic [ACC_W-1:0]        acc_q;     // Accumulator
    logic [RND_W-1:0]        rnd_q;     // Rounding register

    // Pipeline and sequencing state
    logic             start_q;      // Operation started this cycle
    logic             clear_q;      // Clear requested with the start
    logic             s1_valid_q;   // Stage one product ready
    logic             s1_ms_q;      // Multiply-only captured at start
    logic [ACC_W-1:0] prod_q;       // Scaled, sign-extended product
    logic             s2_valid_q;   // Stage two done, round next
    logic             shift_req_q;  // Shift to perform this edge
    logic             shift_done_q; // Shift done, round next
    logic             acc0_wr_q;    // Byte 0 written, round next

    // Decoded bus events
    logic        access;            // Completing edge of a transfer
    logic        wr_en;             // Write takes effect this edge
    logic        addr_ok;           // Address is mapped
    logic [7:0]  addr8;             // Low address byte
    logic [31:0] rd_mux;            // Read data selector
    logic        start;             // Low byte of operand B written

    assign addr8  = paddr[7:0];
    assign access = psel & penable & pready_q;
    assign wr_en  = access & pwrite & addr_ok;
    assign start  = wr_en & (addr8 == ADDR_OPER_B) & pstrb[0]; // RL3

    // Read multiplexer and address decode
    always_comb begin
        rd_mux  = WORD_ZERO;
        addr_ok = 1'b1;
        unique case (addr8)
            ADDR_CONFIG:   rd_mux[5:0]            = cfg_q;
            ADDR_STATUS:   rd_mux[3:0]            = sta_q; // RL20
            ADDR_OPER_A:   rd_mux[OPERAND_W-1:0]  = opa_q;
            ADDR_OPER_B:   rd_mux[OPERAND_W-1:0]  = opb_q;
            ADDR_ACC_B0:   rd_mux[BYTE_W-1:0]     = acc_q[7:0];   // RL23
            ADDR_ACC_B1:   rd_mux[BYTE_W-1:0]     = acc_q[15:8];
            ADDR_ACC_B2:   rd_mux[BYTE_W-1:0]     = acc_q[23:16];
            ADDR_ACC_B3:   rd_mux[BYTE_W-1:0]     = acc_q[31:24];
            ADDR_ACC_OVR:  rd_mux[BYTE_W-1:0]     = acc_q[39:32];
            ADDR_RND_HIGH: rd_mux[BYTE_W-1:0]     = rnd_q[15:8];
            ADDR_RND_LOW:  rd_mux[BYTE_W-1:0]     = rnd_q[7:0];
            default:       addr_ok                = 1'b0;
        endcase
    end

    // One wait state: read data and error are ready when pready rises.
    // Timing of one transfer, edge by edge:
    //   setup edge   - psel high, penable low
    //   access edge  - pready is raised here
    //   finish edge  - psel, penable, pready high
    // Every transfer takes the same path, so the
    // master never has to guess a latency.
    // Read data is only reloaded by reads, so a
    // write leaves the last read value standing.
    // Trade-off: the extra wait state costs one
    // cycle per access but lets the read mux
    // settle through a full clock period.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            prdata_q  <= WORD_ZERO;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= psel & penable & ~pready_q;
            if (psel & penable & ~pready_q) begin
                if (!pwrite) begin
                    prdata_q <= rd_mux;
                end
                pslverr_q <= ~addr_ok;
            end else begin
                pslverr_q <= 1'b0;
            end
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // Operand registers, loaded per byte lane; only a lane 0 load of operand B starts work.
    // Only lanes 0 and 1 carry operand bits;
    // upper lanes are accepted and dropped.
    // Software may reload operand A freely:
    // the product is taken from whatever is
    // held on the edge after the start.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opa_q <= '0;
            opb_q <= '0;
        end else if (wr_en) begin
            if (addr8 == ADDR_OPER_A) begin
                if (pstrb[0]) opa_q[7:0]  <= pwdata[7:0];
                if (pstrb[1]) opa_q[15:8] <= pwdata[15:8];
            end
            if (addr8 == ADDR_OPER_B) begin
                if (pstrb[0]) opb_q[7:0]  <= pwdata[7:0];
                if (pstrb[1]) opb_q[15:8] <= pwdata[15:8];
            end
        end
    end

    // Configuration; hardware drops the command bits once they have acted.
    // A software write on the same edge wins, since it is a fresh command.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= CONFIG_RESET;
        end else if (wr_en && addr8 == ADDR_CONFIG && pstrb[0]) begin
            cfg_q <= engine_config_t'(pwdata[5:0]);
        end else begin
            if (clear_q) begin
                cfg_q.clear_accumulator_cmd <= 1'b0;            // RL7
            end
            if (shift_done_q) begin
                cfg_q.shift_command <= 1'b0;                    // RL11
            end
        end
    end

    // Start and shift strobes, one cycle each.
    // A start is the lane 0 write of operand B;
    // lane 1 of the same write lands on the same edge.
    // The clear request is captured with the
    // start, so a later config write cannot
    // cancel a clear already under way.
    // Shift requests come from any config
    // write that carries the shift bit set.
    // Limitation: a shift written while a
    // stage two result lands is lost, since
    // the pipeline owns the accumulator then.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_q     <= 1'b0;
            clear_q     <= 1'b0;
            shift_req_q <= 1'b0;
            acc0_wr_q   <= 1'b0;
        end else begin
            start_q     <= start;
            clear_q     <= start & cfg_q.clear_accumulator_cmd;  // RL7
            shift_req_q <= wr_en & (addr8 == ADDR_CONFIG) & pstrb[0]
                           & pwdata[5];                          // RL11
            acc0_wr_q   <= wr_en & (addr8 == ADDR_ACC_B0) & pstrb[0];
        end
    end

    // Stage one: signed product, scaled for fractional mode
    logic signed [PRODUCT_W-1:0] prod_raw;
    logic        [ACC_W-1:0]     prod_ext;
    assign prod_raw = $signed(opa_q) * $signed(opb_q);
    assign prod_ext = {{(ACC_W-PRODUCT_W){prod_raw[PRODUCT_W-1]}},
                       prod_raw};

    // Operands are sampled the edge after the start write, so a new write
    // may follow immediately without disturbing the running product.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_valid_q <= 1'b0;
            s1_ms_q    <= 1'b0;
            prod_q     <= '0;
        end else begin
            s1_valid_q <= start_q;                               // RL2 RL24
            if (start_q) begin
                s1_ms_q <= cfg_q.multiply_only_select;
                if (cfg_q.fractional_mode_select) begin
                    prod_q <= {prod_ext[ACC_W-2:0], 1'b0};      // RL22
                end else begin
                    prod_q <= prod_ext;                         // RL21 RL4
                end
            end
        end
    end

    // Stage two: adder with overflow detection.
    // Hardware overflow: both addends share a
    // sign and the sum has the other sign.
    // Soft overflow: bits 39..31 are no longer
    // all copies of the sign, so the value
    // spills out of the low 32-bit word.
    logic [ACC_W-1:0] addend;
    logic [ACC_W-1:0] sum;
    logic             sum_ovf;
    logic             sum_soft;
    assign addend   = s1_ms_q ? '0 : acc_q;                      // RL1 RL8
    assign sum      = addend + prod_q;
    assign sum_ovf  = (addend[ACC_W-1] == prod_q[ACC_W-1])
                      & (sum[ACC_W-1] != addend[ACC_W-1]);
    // Result no longer fits the low 32 bits
    assign sum_soft = ~((&sum[ACC_W-1:31]) | ~(|sum[ACC_W-1:31]));

    // Shifter result
    logic [ACC_W-1:0] shifted;
    assign shifted = cfg_q.shift_direction
                     ? {acc_q[ACC_W-1], acc_q[ACC_W-1:1]}        // RL12 RL13
                     : {acc_q[ACC_W-2:0], 1'b0};

    // Accumulator: clear, then pipeline, then shift, then software bytes.
    // The order matters when two sources meet:
    // a clear always beats a landing result,
    // and hardware beats a software byte.
    // Software writes use lane 0 only, one
    // byte register per aligned word.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= '0;
        end else if (clear_q) begin
            acc_q <= '0;                                         // RL7
        end else if (s1_valid_q) begin
            acc_q <= sum;                                        // RL4 RL9
        end else if (shift_req_q) begin
            acc_q <= shifted;                                    // RL11
        end else if (wr_en && pstrb[0]) begin
            unique case (addr8)
                ADDR_ACC_B0:  acc_q[7:0]   <= pwdata[7:0];       // RL23
                ADDR_ACC_B1:  acc_q[15:8]  <= pwdata[7:0];
                ADDR_ACC_B2:  acc_q[23:16] <= pwdata[7:0];
                ADDR_ACC_B3:  acc_q[31:24] <= pwdata[7:0];
                ADDR_ACC_OVR: acc_q[39:32] <= pwdata[7:0];
                default:      acc_q        <= acc_q;
            endcase
        end
    end

    // Status: overflow flags are sticky until cleared; shifts do not touch
    // this process at all, so the flags ride through them unchanged.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sta_q <= STATUS_RESET;
        end else if (clear_q) begin
            sta_q <= STATUS_RESET;                               // RL7
        end else if (s1_valid_q) begin
            sta_q.zero_flag     <= ~(|sum);                      // RL5 RL25
            sta_q.negative_flag <= sum[ACC_W-1];                 // RL20
            sta_q.soft_overflow_flag <= sta_q.soft_overflow_flag | sum_soft;
            if (!s1_ms_q) begin
                sta_q.hardware_overflow_flag <=
                    sta_q.hardware_overflow_flag | sum_ovf;      // RL10
            end
        end else if (wr_en && addr8 == ADDR_STATUS && pstrb[0]) begin
            sta_q <= engine_status_t'(pwdata[3:0]);              // RL14
        end
    end

    // Stage-three and post-shift rounding requests
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s2_valid_q   <= 1'b0;
            shift_done_q <= 1'b0;
        end else begin
            s2_valid_q   <= s1_valid_q;                          // RL2
            shift_done_q <= shift_req_q;
        end
    end

    // Rounding engine: reads the accumulator, mode bits play no part.
    // Ties round to even so long sums do not
    // drift upward over many operations.
    // The sum is one bit wider than bits
    // 39..16 so the carry of the round-up
    // cannot wrap a large positive value.
    // Saturation only looks at whether the
    // rounded value fits 16 signed bits.
    logic                round_up;
    logic [RND_W+8:0]    wide;          // Bits 39..16 plus one sign bit
    logic                fits;
    logic [RND_W-1:0]    rnd_next;
    assign round_up = (acc_q[15:0] > ROUND_HALF)
                      | ((acc_q[15:0] == ROUND_HALF) & acc_q[16]); // RL18
    assign wide     = {acc_q[ACC_W-1], acc_q[ACC_W-1:16]}
                      + {{(RND_W+8){1'b0}}, round_up};
    assign fits     = (&wide[RND_W+8:RND_W-1]) | ~(|wide[RND_W+8:RND_W-1]);

    always_comb begin
        if (cfg_q.saturate_enable && !fits) begin
            rnd_next = wide[RND_W+8] ? SAT_NEG : SAT_POS;        // RL19
        end else begin
            rnd_next = wide[RND_W-1:0];                          // RL17
        end
    end

    // Only the rounding register is written here, never the accumulator.
    // Three triggers load it: stage three,
    // the edge after a shift, and the edge
    // after a software write of byte 0.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rnd_q <= '0;
        end else if (s2_valid_q || shift_done_q || acc0_wr_q) begin
            rnd_q <= rnd_next;                                   // RL6 RL15 RL16
        end
    end

endmodule

`default_nettype wire

// ---- mac_engine_assertions.sv ----
// Protocol checker for the engine's APB port.
// Assumes it is bound onto the engine top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module mac_engine_assertions
    import mac_engine_pkg::*;
#(
    parameter int ADDR_W = 8            // Address width of the target
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr
);
    // One domain, so clock and reset are given once
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Setup cycle of a transfer
    sequence setup_s;
        psel && !penable;
    endsequence
    // One wait state, then the answer
    sequence answer_s;
        !pready ##1 (pready && penable);
    endsequence

    setup_wait_a: assert property (setup_s |=> answer_s)
        else $error("answer not after one wait state");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    ready_access_a: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    unmapped_err_a: assert property (
        pready && paddr > ADDR_RND_LOW |-> pslverr)
        else $error("unmapped address not refused");
    mapped_ok_a: assert property (
        pready && paddr <= ADDR_RND_LOW && paddr[1:0] == 2'b00
        |-> !pslverr)
        else $error("mapped address refused");
    unmapped_zero_a: assert property (
        pready && pslverr && !pwrite |-> prdata == WORD_ZERO)
        else $error("refused read not zero");
    rdata_hold_a: assert property (
        !$stable(prdata) |-> pready && !pwrite)
        else $error("prdata moved outside a read");
endmodule
`default_nettype wire

// ---- apb_core_model.sv ----
// Processor-side model: an APB master issuing one transfer per call.
// Assumes a single pclk domain and a slave that answers in time.
`timescale 1ns/1ps
`default_nettype none
module apb_core_model (
    input  wire logic        pclk,
    input  wire logic        pready,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    output logic [3:0]       pstrb
);
    bit slow;                           // Adds an idle cycle per transfer

    // Idle bus at time zero
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
        pstrb   = 4'h0;
    end

    // Setup, access until pready, then release with scrambled lines
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        @(posedge pclk);
        if (slow) begin
            @(posedge pclk);
        end
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= 4'hF;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Wait for the answer; only the bench watchdog ends a dead wait
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        // Released lines must not keep looking valid
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask
endmodule
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the multiply-accumulate engine.
// Assumes the engine, its package, the core model and the checker.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import mac_engine_pkg::*;
    logic        pclk, presetn;         // Clock and reset
    logic        psel, penable, pwrite; // APB controls
    logic        pready, pslverr;       // APB answer
    logic [7:0]  paddr;                 // APB address
    logic [31:0] pwdata, prdata;        // APB data
    logic [3:0]  pstrb;                 // Byte strobes
    logic [32:0] exp_q[$];              // Expected {pslverr, prdata}
    logic [59:0] rt[7];                 // Rounding cases
    logic [39:0] acc_m;                 // Reference accumulator
    logic signed [31:0] p;              // Reference product
    logic [15:0] a_v, b_v;              // Random operands
    int          num_errors, total_checks, seed, i;

    apb_core_model core (.pclk(pclk), .pready(pready), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb));
    multiply_accumulate_engine uut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    // Free-running 10 MHz clock
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic end_of_test;
        num_errors += exp_q.size();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [32:0] got, input logic [32:0] e);
        total_checks++;
        if (got !== e) begin
            num_errors++;
            $display("FAIL %0t read %h expected %h", $time, got, e);
        end
    endtask

    // Compares each completed read against the oldest note
    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 &&
            pwrite === 1'b0) begin
            if (exp_q.size() == 0) begin
                num_errors++;
                $display("FAIL %0t read with no expectation", $time);
            end else begin
                chk({pslverr, prdata}, exp_q.pop_front());
            end
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        core.xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        core.xfer(1'b0, a, 32'h0000_0000);
    endtask
    // Byte 0 goes last, since that write retriggers rounding
    task automatic wr_acc(input logic [39:0] v);
        wr(ADDR_ACC_OVR, {24'h00_0000, v[39:32]});
        for (int k = 3; k >= 0; k--) begin
            wr(ADDR_ACC_B0 + 8'(4 * k), {24'h00_0000, v[8*k+:8]});
        end
    endtask
    task automatic rd_acc(input logic [39:0] v);
        rd(ADDR_ACC_OVR, {25'h000_0000, v[39:32]});
        for (int k = 0; k < 4; k++) begin
            rd(ADDR_ACC_B0 + 8'(4 * k), {25'h000_0000, v[8*k+:8]});
        end
    endtask
    task automatic rd_rnd(input logic [15:0] r);
        rd(ADDR_RND_HIGH, {25'h000_0000, r[15:8]});
        rd(ADDR_RND_LOW, {25'h000_0000, r[7:0]});
    endtask
    // Round half to even on bits 31..16, no saturation
    function automatic logic [15:0] rnd_f(input logic [39:0] v);
        rnd_f = v[31:16] + 16'((v[15:0] > ROUND_HALF) ||
                               (v[15:0] == ROUND_HALF && v[16]));
    endfunction

    // Hang guard, far beyond the length of the sequence below
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        $display("FAIL %0t timeout", $time);
        end_of_test;
    end

    initial begin
        seed = 85935;
        // Fields: saturate, overflow byte, acc bits 31..0, rounded
        rt = '{60'h000_1234_8001_1235, 60'h000_1234_7fff_1234,
               60'h000_1235_8000_1236, 60'h000_1234_8000_1234,
               60'h100_7fff_8001_7fff, 60'h000_7fff_8001_8000,
               60'h1ff_7f00_0000_8000};
        presetn = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 11; i++) rd(8'(4 * i), 33'h0_0000_0000);
        rd(8'h2C, 33'h1_0000_0000);
        // Fractional accumulate with clear: 0.5*0.25 + 0.5*-0.25
        wr(ADDR_CONFIG, 32'h0000_000A);
        wr(ADDR_OPER_A, 32'h0000_4000);
        wr(ADDR_OPER_B, 32'h0000_2000);
        rd_acc(40'h00_1000_0000);
        rd(ADDR_CONFIG, 33'h0_0000_0002);
        wr(ADDR_OPER_B, 32'h0000_E000);
        rd_acc(40'h00_0000_0000);
        rd(ADDR_STATUS, 33'h0_0000_0004);
        rd_rnd(16'h0000);
        // Integer multiply-only with a negative product
        wr(ADDR_CONFIG, 32'h0000_0001);
        wr(ADDR_OPER_A, 32'h0000_1234);
        wr(ADDR_OPER_B, 32'h0000_FEDC);
        rd_acc(40'hff_ffeb_3cb0);
        rd(ADDR_STATUS, 33'h0_0000_0001);
        rd_rnd(16'hffeb);
        // One left shift, two right shifts
        wr_acc(40'h40_8844_2211);
        wr(ADDR_CONFIG, 32'h0000_0020);
        rd_acc(40'h81_1088_4422);
        rd(ADDR_CONFIG, 33'h0_0000_0000);
        wr(ADDR_CONFIG, 32'h0000_0030);
        wr(ADDR_CONFIG, 32'h0000_0030);
        rd_acc(40'he0_4422_1108);
        rd_rnd(16'h4422);
        rd(ADDR_STATUS, 33'h0_0000_0001);
        // Signed overflow, then multiply-only keeps the overflow flag
        wr_acc(40'h7f_ffff_ffff);
        wr(ADDR_CONFIG, 32'h0000_0000);
        wr(ADDR_OPER_A, 32'h0000_0001);
        wr(ADDR_OPER_B, 32'h0000_0001);
        rd(ADDR_STATUS, 33'h0_0000_000B);
        wr(ADDR_CONFIG, 32'h0000_0001);
        wr(ADDR_OPER_B, 32'h0000_0001);
        rd(ADDR_STATUS, 33'h0_0000_000A);
        // Rounding ties and saturation, alternating number mode
        for (i = 0; i < 7; i++) begin
            wr(ADDR_CONFIG, {29'h0, rt[i][56], 1'(i), 1'b0});
            wr_acc(rt[i][55:16]);
            rd_rnd(rt[i][15:0]);
            rd_acc(rt[i][55:16]);
        end
        // Random integer accumulations, first one clears
        wr(ADDR_CONFIG, 32'h0000_0008);
        acc_m = 40'h00_0000_0000;
        for (i = 0; i < 6; i++) begin
            core.slow = 1'($random(seed));
            a_v = 16'($random(seed));
            b_v = 16'($random(seed));
            wr(ADDR_OPER_A, {16'h0000, a_v});
            wr(ADDR_OPER_B, {16'h0000, b_v});
            p = $signed(a_v) * $signed(b_v);
            acc_m = acc_m + {{8{p[31]}}, p};
        end
        rd_acc(acc_m);
        rd_rnd(rnd_f(acc_m));
        // Refused write leaves nothing behind
        wr(8'h30, 32'hFFFF_FFFF);
        rd(8'h30, 33'h1_0000_0000);
        repeat (5) @(posedge pclk);
        end_of_test;
    end
endmodule

bind multiply_accumulate_engine mac_engine_assertions #(
    .ADDR_W(ADDR_W)) chk_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
`default_nettype wire
